/* File: verilog/rfid_cfg_regs.vh */
// Register map, field positions, masks and timing of the reader configuration bank.
// Assumes a single 100 MHz system clock and the serial configuration pins.
`ifndef RFID_CFG_REGS_VH
`define RFID_CFG_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADDR_ANALOG 4'h0
`define ADDR_POWER 4'h1
`define ADDR_RSVD 4'h2
`define ADDR_DIGITAL 4'h3
`define ADDR_PAT_FIRST 4'h4
`define ADDR_PAT_LAST 4'h9
`define ADDR_ENC_REF 4'hA
`define ADDR_DEC_REF 4'hB
`define ADDR_SLICER 4'hC

// ----------------------------------------------------------------------------
// Writable bit masks and reset value
// ----------------------------------------------------------------------------
`define MASK_ANALOG 8'hFF
`define MASK_POWER 8'h03
`define MASK_DIGITAL 8'h1F
`define MASK_ENC_REF 8'h1F
`define MASK_SLICER 8'h3F
`define REG_RESET 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_CLK_FREQ 7
`define BIT_CLK_DIS 6
`define BIT_MOD_DEPTH 5
`define BIT_SUBCARRIER 4
`define BIT_BYPASS 2
`define BIT_VOTE_MODE 4
`define BIT_VOTE_EN 3
`define BIT_OSEL_HI 2
`define BIT_OSEL_LO 1
`define BIT_ENC_EN 0
`define BIT_SLC_EN 0
`define BIT_SLC_HI 5
`define BIT_SLC_LO 1
`define BIT_PWR_HI 1
`define BIT_PWR_LO 0
`define BIT_EREF_HI 4
`define BIT_EREF_LO 0
`define SLOT_OFFSET 9'h001

// ----------------------------------------------------------------------------
// Codes and constants
// ----------------------------------------------------------------------------
`define PWR_IDLE 2'h0
`define PWR_TX_ON 2'h1
`define PWR_DOWN 2'h3
`define OSEL_AM 2'h0
`define OSEL_FM 2'h1
`define OSEL_FSK 2'h2
`define OSEL_PSK 2'h3
`define SYM_FIXED 3'h6
`define SYM_FIXED_VAL 8'hFF
`define FRAME_ADDR_END 4'h5
`define FRAME_LAST 4'hD
`define PAT_COUNT 6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MCLK_PERIOD_NS 10
`define T_START_NS 1000
`define T_START_CYC ((`T_START_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

/* File: verilog/pin_sync.v */
// Two-flop synchroniser for a group of pins.
// Assumes the pins are asynchronous to mclk_i.
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Pins
  input wire [WIDTH-1:0] pin_i,
  output reg [WIDTH-1:0] pin_o
);
  reg [WIDTH-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta[g] <= 1'b0;
          pin_o[g] <= 1'b0;
        end else begin
          meta[g] <= pin_i[g];
          pin_o[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule // pin_sync

/* File: verilog/pattern_store.v */
// Six-word store for the encoder symbol patterns, two registered read ports.
// Assumes a single writer on mclk_i.
`timescale 1ns/1ps
`include "rfid_cfg_regs.vh"
module pattern_store (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Write port
  input wire wr_en_i,
  input wire [2:0] wr_idx_i,
  input wire [7:0] wr_data_i,
  // Read ports
  input wire [2:0] rd_a_idx_i,
  output reg [7:0] rd_a_data_o,
  input wire [2:0] rd_b_idx_i,
  output reg [7:0] rd_b_data_o
);
  reg [7:0] mem [0:`PAT_COUNT-1];

  genvar g;
  generate
    for (g = 0; g < `PAT_COUNT; g = g + 1) begin : g_word
      always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          mem[g] <= `REG_RESET;
        end else if (wr_en_i && (wr_idx_i == g)) begin
          mem[g] <= wr_data_i;
        end
      end
    end
  endgenerate

  // Out-of-range index reads zero
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_a_data_o <= 8'h00;
      rd_b_data_o <= 8'h00;
    end else begin
      rd_a_data_o <= (rd_a_idx_i < `PAT_COUNT) ? mem[rd_a_idx_i] : 8'h00;
      rd_b_data_o <= (rd_b_idx_i < `PAT_COUNT) ? mem[rd_b_idx_i] : 8'h00;
    end
  end
endmodule // pattern_store

/* File: verilog/rfid_cfg_bank.v */
// Configuration register bank of the contactless reader, written over the serial pins.
// Assumes the host frames 13 bits while cfg_mode_i is low: read flag, 4 address bits,
// 8 data bits, all MSB first, sampled on rising serial_clock_in edges.
`timescale 1ns/1ps
`include "rfid_cfg_regs.vh"
module rfid_cfg_bank (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Serial configuration pins
  input wire serial_clock_in_i,
  input wire serial_data_i,
  input wire cfg_mode_i,
  output reg serial_data_o,
  // Receive chain inputs
  input wire rx_am_i,
  input wire rx_fm_i,
  input wire rx_fsk_i,
  input wire rx_psk_i,
  output reg rx_data_o,
  // Encoder symbol lookup
  input wire [2:0] tx_symbol_i,
  output reg [7:0] tx_pattern_o,
  // Analog controls
  output reg clkout_freq_select_o,
  output reg clkout_disable_o,
  output reg tx_mod_depth_o,
  output reg rx_subcarrier_select_o,
  output reg analog_chain_bypass_o,
  // Power controls
  output reg [1:0] power_mode_field_o,
  output reg osc_run_o,
  output reg tx_on_o,
  output reg analog_on_o,
  // Digital controls
  output reg vote_weight_mode_o,
  output reg vote_filter_enable_o,
  output reg [1:0] rx_output_select_o,
  output reg tx_encoder_enable_o,
  output reg [4:0] encoder_period_value_o,
  output reg [8:0] vote_slot_length_o,
  output reg [4:0] slicer_switch_delay_o,
  output reg slicer_switch_enable_o
);

  // --------------------------------------------------------------------------
  // Pattern index decode
  // --------------------------------------------------------------------------
  function [2:0] pat_idx;
    input [3:0] addr;
    reg [3:0] offs;
    begin
      // Offset from the first pattern address; out-of-range gives the unused index
      offs = addr - `ADDR_PAT_FIRST;
      pat_idx = offs[2:0];
      if (addr < `ADDR_PAT_FIRST || addr > `ADDR_PAT_LAST) begin
        pat_idx = 3'h7;
      end
    end
  endfunction

  function is_pat;
    input [3:0] addr;
    begin
      is_pat = (addr >= `ADDR_PAT_FIRST) && (addr <= `ADDR_PAT_LAST);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  wire [6:0] pins_s;
  wire ck_s;
  wire din_s;
  wire mode_s;
  reg ck_d;
  wire ck_rise;
  wire ck_fall;

  pin_sync #(
    .WIDTH(7)
  ) u_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .pin_i({rx_psk_i, rx_fsk_i, rx_fm_i, rx_am_i, cfg_mode_i, serial_data_i,
      serial_clock_in_i}),
    .pin_o(pins_s)
  );

  assign ck_s = pins_s[0];
  assign din_s = pins_s[1];
  assign mode_s = pins_s[2];
  assign ck_rise = ck_s & ~ck_d;
  assign ck_fall = ~ck_s & ck_d;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg [7:0] analog_front_config;
  reg [7:0] power_mode_reg;
  reg [7:0] digital_receive_config;
  reg [7:0] encoder_period_ref;
  reg [7:0] decoder_slot_ref;
  reg [7:0] slicer_delay_ctrl;

  reg [3:0] bit_cnt;
  reg rd_flag;
  reg [3:0] addr_sh;
  reg [7:0] data_sh;
  reg [7:0] out_sh;
  reg wr_fire;
  reg [15:0] start_cnt;
  reg waking;

  wire pwr_down;
  wire frame_ok;
  wire [3:0] addr_next;
  wire [7:0] data_next;
  wire [7:0] pat_rd;
  wire [7:0] pat_tx;
  reg [7:0] rd_mux;
  wire [1:0] power_field;
  wire [1:0] osel_field;
  reg sym_fixed_d;

  assign power_field = power_mode_reg[`BIT_PWR_HI:`BIT_PWR_LO];
  assign osel_field = digital_receive_config[`BIT_OSEL_HI:`BIT_OSEL_LO];
  // Writes are refused while the oscillator is off or restarting
  assign pwr_down = (power_field == `PWR_DOWN) | waking;
  assign frame_ok = ~mode_s & ~pwr_down;
  assign addr_next = {addr_sh[2:0], din_s};
  assign data_next = {data_sh[6:0], din_s};

  pattern_store u_pat (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(wr_fire && is_pat(addr_sh)),
    .wr_idx_i(pat_idx(addr_sh)),
    .wr_data_i(data_sh),
    .rd_a_idx_i(pat_idx(addr_sh)),
    .rd_a_data_o(pat_rd),
    .rd_b_idx_i(tx_symbol_i),
    .rd_b_data_o(pat_tx)
  );

  // --------------------------------------------------------------------------
  // Serial frame engine
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ck_d <= 1'b0;
      bit_cnt <= 4'h0;
      rd_flag <= 1'b0;
      addr_sh <= 4'h0;
      data_sh <= 8'h00;
      out_sh <= 8'h00;
      wr_fire <= 1'b0;
      serial_data_o <= 1'b0;
    end else begin
      ck_d <= ck_s;
      wr_fire <= 1'b0;
      if (!frame_ok) begin
        bit_cnt <= 4'h0;
        serial_data_o <= 1'b0;
      end else if (ck_rise) begin
        if (bit_cnt == 4'h0) begin
          rd_flag <= din_s;
        end else if (bit_cnt < `FRAME_ADDR_END) begin
          addr_sh <= addr_next;
        end else begin
          data_sh <= data_next;
        end
        if (bit_cnt == `FRAME_LAST - 4'h1) begin
          wr_fire <= ~rd_flag;
          bit_cnt <= 4'h0;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (ck_fall && rd_flag && bit_cnt >= `FRAME_ADDR_END) begin
        if (bit_cnt == `FRAME_ADDR_END) begin
          serial_data_o <= rd_mux[7];
          out_sh <= {rd_mux[6:0], 1'b0};
        end else begin
          serial_data_o <= out_sh[7];
          out_sh <= {out_sh[6:0], 1'b0};
        end
      end
    end
  end

  // Read-back; masked-off and reserved bits come back as zero
  always @* begin
    case (addr_sh)
      `ADDR_ANALOG: rd_mux = analog_front_config;
      `ADDR_POWER: rd_mux = power_mode_reg;
      `ADDR_DIGITAL: rd_mux = digital_receive_config;
      `ADDR_ENC_REF: rd_mux = encoder_period_ref;
      `ADDR_DEC_REF: rd_mux = decoder_slot_ref;
      `ADDR_SLICER: rd_mux = slicer_delay_ctrl;
      default: rd_mux = is_pat(addr_sh) ? pat_rd : 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Register writes and wake-up
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      analog_front_config <= `REG_RESET;
      power_mode_reg <= `REG_RESET;
      digital_receive_config <= `REG_RESET;
      encoder_period_ref <= `REG_RESET;
      decoder_slot_ref <= `REG_RESET;
      slicer_delay_ctrl <= `REG_RESET;
      start_cnt <= 16'h0000;
      waking <= 1'b0;
    end else begin
      if (wr_fire) begin
        case (addr_sh)
          `ADDR_ANALOG: analog_front_config <= data_sh & `MASK_ANALOG;
          `ADDR_POWER: power_mode_reg <= data_sh & `MASK_POWER;
          `ADDR_DIGITAL: digital_receive_config <= data_sh & `MASK_DIGITAL;
          `ADDR_ENC_REF: encoder_period_ref <= data_sh & `MASK_ENC_REF;
          `ADDR_DEC_REF: decoder_slot_ref <= data_sh;
          `ADDR_SLICER: slicer_delay_ctrl <= data_sh & `MASK_SLICER;
          default: ;
        endcase
      end
      // Wake needs a clock fall with data low; the bank sets the mode to idle when the restart window ends
      if (power_field == `PWR_DOWN && !waking && ck_fall && !din_s) begin
        waking <= 1'b1;
        start_cnt <= 16'h0000;
      end else if (waking) begin
        if (start_cnt == `T_START_CYC - 1) begin
          waking <= 1'b0;
          power_mode_reg <= {6'h00, `PWR_IDLE};
        end else begin
          start_cnt <= start_cnt + 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Analog front-end controls
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clkout_freq_select_o <= 1'b0;
      clkout_disable_o <= 1'b0;
      tx_mod_depth_o <= 1'b0;
      rx_subcarrier_select_o <= 1'b0;
      analog_chain_bypass_o <= 1'b0;
    end else begin
      clkout_freq_select_o <= analog_front_config[`BIT_CLK_FREQ];
      clkout_disable_o <= analog_front_config[`BIT_CLK_DIS];
      tx_mod_depth_o <= analog_front_config[`BIT_MOD_DEPTH];
      rx_subcarrier_select_o <= analog_front_config[`BIT_SUBCARRIER];
      analog_chain_bypass_o <= analog_front_config[`BIT_BYPASS];
    end
  end

  // --------------------------------------------------------------------------
  // Power state controls
  // --------------------------------------------------------------------------
  // Code 10 is unused and treated like idle; the restart window counts as power down
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_mode_field_o <= `PWR_IDLE;
      osc_run_o <= 1'b1;
      tx_on_o <= 1'b0;
      analog_on_o <= 1'b0;
    end else begin
      power_mode_field_o <= power_field;
      osc_run_o <= ~pwr_down;
      tx_on_o <= (power_field == `PWR_TX_ON) & ~waking;
      analog_on_o <= (power_field == `PWR_TX_ON) & ~waking;
    end
  end

  // --------------------------------------------------------------------------
  // Digital receive controls
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vote_weight_mode_o <= 1'b0;
      vote_filter_enable_o <= 1'b0;
      rx_output_select_o <= `OSEL_AM;
      tx_encoder_enable_o <= 1'b0;
    end else begin
      vote_weight_mode_o <= digital_receive_config[`BIT_VOTE_MODE];
      vote_filter_enable_o <= digital_receive_config[`BIT_VOTE_EN];
      rx_output_select_o <= osel_field;
      tx_encoder_enable_o <= digital_receive_config[`BIT_ENC_EN];
    end
  end

  // --------------------------------------------------------------------------
  // Timing references
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      encoder_period_value_o <= 5'h00;
      vote_slot_length_o <= `SLOT_OFFSET;
      slicer_switch_delay_o <= 5'h00;
      slicer_switch_enable_o <= 1'b0;
    end else begin
      encoder_period_value_o <= encoder_period_ref[`BIT_EREF_HI:`BIT_EREF_LO];
      vote_slot_length_o <= {1'b0, decoder_slot_ref} + `SLOT_OFFSET;
      slicer_switch_delay_o <= slicer_delay_ctrl[`BIT_SLC_HI:`BIT_SLC_LO];
      slicer_switch_enable_o <= slicer_delay_ctrl[`BIT_SLC_EN];
    end
  end

  // --------------------------------------------------------------------------
  // Encoder symbol lookup
  // --------------------------------------------------------------------------
  // The fixed symbol is delayed like the stored read, so a symbol change never glitches
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sym_fixed_d <= 1'b0;
      tx_pattern_o <= 8'h00;
    end else begin
      sym_fixed_d <= (tx_symbol_i == `SYM_FIXED);
      if (sym_fixed_d) begin
        tx_pattern_o <= `SYM_FIXED_VAL;
      end else begin
        tx_pattern_o <= pat_tx;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive output routing
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_data_o <= 1'b0;
    end else begin
      case (osel_field)
        `OSEL_AM: rx_data_o <= pins_s[3];
        `OSEL_FM: rx_data_o <= pins_s[4];
        `OSEL_FSK: rx_data_o <= pins_s[5];
        `OSEL_PSK: rx_data_o <= pins_s[6];
        default: rx_data_o <= 1'b0;
      endcase
    end
  end

endmodule // rfid_cfg_bank

/* File: tb/cfg_host_model.sv */
// Host model for the serial configuration pins of the reader bank.
// Assumes the bank samples these pins with its own clock; link period 125 ns.
`timescale 1ns/1ps
module cfg_host_model (
  // Serial pins toward the bank
  output logic sck_o,
  output logic sdi_o,
  output logic mode_o,
  // Read-back pin from the bank
  input wire logic sdo_i
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // Data idles high so a clock glitch can never look like a wake request
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b1;
    mode_o = 1'b1;
  end

  // ----------------------------------------
  // Frames and wake
  // ----------------------------------------
  task automatic frame(input logic rd, input logic [3:0] adr, input logic [7:0] wd,
      output logic [7:0] rdat);
    logic [12:0] bits;
    bits = {rd, adr, wd};
    rdat = 8'h00;
    mode_o = 1'b0;
    #200;
    for (int i = 12; i >= 0; i--) begin
      sdi_o = bits[i];
      #62.5;
      if (i < 8) rdat[i] = sdo_i;
      sck_o = 1'b1;
      #62.5;
      sck_o = 1'b0;
    end
    #62.5;
    sdi_o = 1'b1;
    mode_o = 1'b1;
    #200;
  endtask

  // Falling clock with data low restarts a powered-down bank
  task automatic wake();
    sdi_o = 1'b0;
    #62.5 sck_o = 1'b1;
    #62.5 sck_o = 1'b0;
    #62.5 sdi_o = 1'b1;
  endtask
endmodule // cfg_host_model

/* File: tb/rfid_cfg_bank_monitor.sv */
// Concurrent checks on the ports of the configuration bank.
// Assumes one clock domain, mclk_i, with asynchronous reset arst_n_i.
`timescale 1ns/1ps
module rfid_cfg_bank_monitor (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Inputs
  input wire cfg_mode_i,
  input wire rx_am_i,
  input wire rx_fm_i,
  input wire rx_fsk_i,
  input wire rx_psk_i,
  input wire [2:0] tx_symbol_i,
  // Outputs
  input wire rx_data_o,
  input wire [7:0] tx_pattern_o,
  input wire [1:0] power_mode_field_o,
  input wire osc_run_o,
  input wire tx_on_o,
  input wire analog_on_o,
  input wire [1:0] rx_output_select_o,
  input wire [8:0] vote_slot_length_o,
  input wire [4:0] encoder_period_value_o,
  input wire [4:0] slicer_switch_delay_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire [3:0] srcs = {rx_psk_i, rx_fsk_i, rx_fm_i, rx_am_i};
  wire sel_src = srcs[rx_output_select_o];

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_osc_off;
    (power_mode_field_o == 2'h3)[*2] |-> !osc_run_o && !tx_on_o;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs in power down");
  property p_osc_on;
    (power_mode_field_o != 2'h3)[*2] |-> osc_run_o;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator stopped outside power down");
  property p_tx_on;
    tx_on_o |-> power_mode_field_o == 2'h1 || $past(power_mode_field_o) == 2'h1;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("transmitter on in wrong state");
  property p_analog_on;
    tx_on_o == analog_on_o;
  endproperty
  a_analog_on: assert property (p_analog_on) else $error("analog and transmitter differ");
  property p_slot;
    vote_slot_length_o >= 9'h001 && vote_slot_length_o <= 9'h100;
  endproperty
  a_slot: assert property (p_slot) else $error("slot length out of range");
  property p_rx_sel;
    ($stable(sel_src) && $stable(rx_output_select_o))[*6] |-> rx_data_o == sel_src;
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("receive output not the selected source");
  property p_sym_fixed;
    tx_symbol_i == 3'h6 |-> ##2 tx_pattern_o == 8'hFF;
  endproperty
  a_sym_fixed: assert property (p_sym_fixed) else $error("fixed symbol not all ones");
  property p_freeze;
    (power_mode_field_o == 2'h3)[*2] |-> $stable(encoder_period_value_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("register changed in power down");
  property p_mode_hold;
    cfg_mode_i[*8] |-> $stable(slicer_switch_delay_o);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("slicer changed outside frames");

  c_down: cover property (power_mode_field_o == 2'h3 ##1 !osc_run_o);
  c_tx: cover property (tx_on_o);
  c_psk: cover property (rx_output_select_o == 2'h3);
endmodule // rfid_cfg_bank_monitor

bind rfid_cfg_bank rfid_cfg_bank_monitor mon_u (.mclk_i, .arst_n_i, .cfg_mode_i, .rx_am_i,
  .rx_fm_i, .rx_fsk_i, .rx_psk_i, .tx_symbol_i, .rx_data_o, .tx_pattern_o,
  .power_mode_field_o, .osc_run_o, .tx_on_o, .analog_on_o, .rx_output_select_o,
  .vote_slot_length_o, .encoder_period_value_o, .slicer_switch_delay_o);

/* File: tb/rfid_cfg_bank_bench.sv */
// Self-checking bench for the configuration bank against a register model.
// Assumes the host model drives the serial pins; 100 MHz clock.
`timescale 1ns/1ps
module rfid_cfg_bank_bench;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic serial_clock_in_i, serial_data_i, cfg_mode_i, serial_data_o;
  logic rx_am_i = 1'b0, rx_fm_i = 1'b0, rx_fsk_i = 1'b0, rx_psk_i = 1'b0, rx_data_o;
  logic [2:0] tx_symbol_i = 3'h0;
  logic [7:0] tx_pattern_o;
  logic clkout_freq_select_o, clkout_disable_o, tx_mod_depth_o, rx_subcarrier_select_o;
  logic analog_chain_bypass_o, osc_run_o, tx_on_o, analog_on_o, vote_weight_mode_o;
  logic vote_filter_enable_o, tx_encoder_enable_o, slicer_switch_enable_o;
  logic [1:0] power_mode_field_o, rx_output_select_o;
  logic [4:0] encoder_period_value_o, slicer_switch_delay_o;
  logic [8:0] vote_slot_length_o;
  int exp_reg [16];
  int failures = 0;
  int checked = 0;

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  rfid_cfg_bank dut_u (.mclk_i, .arst_n_i, .serial_clock_in_i, .serial_data_i, .cfg_mode_i,
    .serial_data_o, .rx_am_i, .rx_fm_i, .rx_fsk_i, .rx_psk_i, .rx_data_o, .tx_symbol_i,
    .tx_pattern_o, .clkout_freq_select_o, .clkout_disable_o, .tx_mod_depth_o,
    .rx_subcarrier_select_o, .analog_chain_bypass_o, .power_mode_field_o, .osc_run_o,
    .tx_on_o, .analog_on_o, .vote_weight_mode_o, .vote_filter_enable_o, .rx_output_select_o,
    .tx_encoder_enable_o, .encoder_period_value_o, .vote_slot_length_o,
    .slicer_switch_delay_o, .slicer_switch_enable_o);
  cfg_host_model host_u (.sck_o(serial_clock_in_i), .sdi_o(serial_data_i),
    .mode_o(cfg_mode_i), .sdo_i(serial_data_o));

  // ----------------------------------------
  // Model and compare tasks
  // ----------------------------------------
  function automatic int mask(input int a);
    case (a)
      1: mask = 'h03;
      3, 10: mask = 'h1F;
      12: mask = 'h3F;
      2, 13, 14, 15: mask = 'h00;
      default: mask = 'hFF;
    endcase
  endfunction
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_reg(input int a, input logic [7:0] got);
    chk($sformatf("reg %0d", a), exp_reg[a][7:0], {1'b0, got});
  endtask
  task automatic wr(input int a, input int d);
    logic [7:0] r;
    host_u.frame(1'b0, a[3:0], d[7:0], r);
    exp_reg[a] = d & mask(a);
  endtask
  task automatic rd(input int a);
    logic [7:0] r;
    host_u.frame(1'b1, a[3:0], 8'h00, r);
    chk_reg(a, r);
  endtask
  task automatic chk_outs();
    logic [7:0] an, dg, sl;
    an = exp_reg[0];
    dg = exp_reg[3];
    sl = exp_reg[12];
    chk("clk_freq", an[7], clkout_freq_select_o);
    chk("clk_dis", an[6], clkout_disable_o);
    chk("mod_depth", an[5], tx_mod_depth_o);
    chk("subcarrier", an[4], rx_subcarrier_select_o);
    chk("bypass", an[2], analog_chain_bypass_o);
    chk("power", exp_reg[1], power_mode_field_o);
    chk("vote_mode", dg[4], vote_weight_mode_o);
    chk("vote_en", dg[3], vote_filter_enable_o);
    chk("osel", dg[2:1], rx_output_select_o);
    chk("enc_en", dg[0], tx_encoder_enable_o);
    chk("enc_ref", exp_reg[10], encoder_period_value_o);
    chk("slc_dly", sl[5:1], slicer_switch_delay_o);
    chk("slc_en", sl[0], slicer_switch_enable_o);
    chk("slot", exp_reg[11] + 1, vote_slot_length_o);
  endtask
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int d, n;
    logic [3:0] v;
    foreach (exp_reg[a]) exp_reg[a] = 0;
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    d = $urandom(32'hCE4B);
    chk_outs();
    chk("osc_run", 1'b1, osc_run_o);
    for (int a = 0; a < 16; a++) rd(a);
    $display("reset values done");
    for (int a = 0; a < 16; a++) begin
      d = $urandom;
      if (a == 0) d = (d & 'hF4) | 'h03;
      if (a == 1) d = d & 'hFC;
      wr(a, d);
    end
    chk_outs();
    for (int a = 0; a < 16; a++) rd(a);
    $display("random writes done");
    for (int c = 0; c < 4; c++) begin
      wr(3, c << 1);
      for (int k = 0; k < 4; k++) begin
        v = 4'($urandom);
        @(posedge mclk_i);
        {rx_am_i, rx_fm_i, rx_fsk_i, rx_psk_i} <= v;
        repeat (8) @(posedge mclk_i);
        chk("rx_data", v[3-c], rx_data_o);
      end
    end
    $display("receive select done");
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk_i);
      tx_symbol_i <= s[2:0];
      repeat (3) @(posedge mclk_i);
      #1;
      d = (s < 6) ? exp_reg[4+s] : (s == 6) ? 'hFF : 'h00;
      chk("pattern", d[7:0], tx_pattern_o);
    end
    $display("patterns done");
    wr(1, 1);
    chk_outs();
    chk("tx_on", 1'b1, tx_on_o);
    chk("analog_on", 1'b1, analog_on_o);
    wr(1, 3);
    chk("osc_off", 1'b0, osc_run_o);
    host_u.wake();
    n = 0;
    while (osc_run_o !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 400) begin
      failures++;
      $display("[FAIL] wake expected osc_run 1 seen %b", osc_run_o);
    end
    chk("restart", (n >= 85 && n <= 115), 1'b1);
    repeat (2) @(posedge mclk_i);
    exp_reg[1] = 0;
    chk_outs();
    wr(10, 'hFF);
    rd(10);
    $display("power modes done");
    test_done();
  end
endmodule // rfid_cfg_bank_bench
